// ### inc/port_cd_pin_params.svh
// Constants for the port C and port D pin function selection.
`ifndef PORT_CD_PIN_PARAMS_SVH
`define PORT_CD_PIN_PARAMS_SVH

// Prescaler select codes that pick an external clock pin.
`define PSC_EXT_CLK_A 3'h4
`define PSC_EXT_CLK_B 3'h5
`define PSC_EXT_CLK_C 3'h6

// Upper two bits of an I/O control field that make it a capture input.
`define IO_FIELD_CAPTURE_TOP 2'h2

// Wake-up mask level that lets the pin through.
`define WAKE_UNMASKED 1'h0

// Level that a gated wake-up input rests at; the wake-up inputs are active low.
`define WAKE_IDLE 1'h1

// Direction bit value for general output.
`define DIR_OUTPUT 1'h1

// Serial mode select value for the clocked-synchronous mode.
`define SERIAL_MODE_CLOCKED 1'h0

// Level of a timer or serial input that is not routed to its pin.
`define ROUTE_IDLE 1'h0

`endif

// ### inc/port_cd_pin_pkg.sv
// Types shared by the port C and port D pin function selection.
package port_cd_pin_pkg;

   typedef logic [2:0] psc_type;
   typedef logic [3:0] io_field_type;
   typedef logic [5:0] port_c_vec_type;
   typedef logic [13:8] wake_vec_type;

endpackage

// ### design/pin_cell.sv
// One pin's output driver choice between an alternate function and general I/O.
`timescale 1ns/1ps
`include "port_cd_pin_params.svh"

module pin_cell (
   input wire logic alt_in_en,
   input wire logic alt_out_en,
   input wire logic alt_out,
   input wire logic direction,
   input wire logic gpio_out,
   output logic pin_out,
   output logic pin_oe
);

   // An alternate input wins over everything, so the pin is released then.
   assign pin_out = alt_out_en ? alt_out : gpio_out;
   assign pin_oe = !alt_in_en && (alt_out_en || (direction == `DIR_OUTPUT));

endmodule

// ### design/port_c_d_pin_function_select.sv
// Pin function selection for port C pins 5 to 0 and port D pins 7 and 6.
//
// Summary of operation
// RULE1 - C5 drives timer1 compare B when selected, else direction picks input/output.
// RULE2 - C5 feeds external clock C when timer0 or timer2 prescaler is 110.
// RULE3 - C5 also feeds external clock C in timer1 phase counting mode.
// RULE4 - C5 feeds timer1 capture B in normal mode or phase mode with field 10xx.
// RULE5 - C4 drives timer1 compare A when selected, else direction picks input/output.
// RULE6 - C4 feeds timer1 capture A in normal mode or phase mode with field 10xx.
// RULE7 - C3 feeds external clock B on prescaler 101 anywhere or timer0 phase mode.
// RULE8 - C3 feeds timer0 capture D in normal mode or phase mode with field 10xx.
// RULE9 - C2 feeds external clock A on prescaler 100 anywhere or timer0 phase mode.
// RULE10 - C2 feeds timer0 capture C in normal mode or phase mode with field 10xx.
// RULE11 - C3 and C2 drive timer0 compare D and C when selected, else general I/O.
// RULE12 - C1 and C0 drive timer0 compare B and A when selected, else general I/O.
// RULE13 - C1 feeds timer0 capture B in normal mode or phase mode with field 10xx.
// RULE14 - C0 feeds timer0 capture A in normal mode or phase mode with field 10xx.
// RULE15 - C5 to C0 feed wake-up inputs 13 to 8 while their mask bit is 0.
// RULE16 - D7 chip-select input enabled: clocked mode, slave, or master with field 01/10.
// RULE17 - D7 chip-select output: clocked master with upper bit; input first, then output.
// RULE18 - D6 serial clock input enabled when slave with clock-select set, either mode.
// RULE19 - D6 serial clock output when master with clock-select; input wins, then output.
// RULE20 - Selection is combinational, so a setting acts on the pin in the same cycle.
`timescale 1ns/1ps
`include "port_cd_pin_params.svh"

module port_c_d_pin_function_select (
   input wire logic clk,
   input wire logic nrst,
   // Port C pins and port registers.
   input wire port_cd_pin_pkg::port_c_vec_type pin_c_in,
   output port_cd_pin_pkg::port_c_vec_type pin_c_out,
   output port_cd_pin_pkg::port_c_vec_type pin_c_oe,
   input wire port_cd_pin_pkg::port_c_vec_type pin_c_direction,
   input wire port_cd_pin_pkg::port_c_vec_type pin_c_data,
   output port_cd_pin_pkg::port_c_vec_type pin_c_level,
   // Timer channel modes and settings.
   input wire logic timer0_normal_mode,
   input wire logic timer0_phase_mode,
   input wire logic timer1_normal_mode,
   input wire logic timer1_phase_mode,
   input wire port_cd_pin_pkg::psc_type timer0_prescaler_select,
   input wire port_cd_pin_pkg::psc_type timer1_prescaler_select,
   input wire port_cd_pin_pkg::psc_type timer2_prescaler_select,
   input wire port_cd_pin_pkg::io_field_type timer1_io_field_a,
   input wire port_cd_pin_pkg::io_field_type timer1_io_field_b,
   input wire port_cd_pin_pkg::io_field_type timer0_io_field_a,
   input wire port_cd_pin_pkg::io_field_type timer0_io_field_b,
   input wire port_cd_pin_pkg::io_field_type timer0_io_field_c,
   input wire port_cd_pin_pkg::io_field_type timer0_io_field_d,
   // Timer compare outputs and their output selections.
   input wire logic timer1_cmp_b,
   input wire logic timer1_cmp_b_oe,
   input wire logic timer1_cmp_a,
   input wire logic timer1_cmp_a_oe,
   input wire logic timer0_cmp_d,
   input wire logic timer0_cmp_d_oe,
   input wire logic timer0_cmp_c,
   input wire logic timer0_cmp_c_oe,
   input wire logic timer0_cmp_b,
   input wire logic timer0_cmp_b_oe,
   input wire logic timer0_cmp_a,
   input wire logic timer0_cmp_a_oe,
   // Timer inputs fed from the pins.
   output logic ext_clk_in_a,
   output logic ext_clk_in_b,
   output logic ext_clk_in_c,
   output logic timer1_cap_b,
   output logic timer1_cap_a,
   output logic timer0_cap_d,
   output logic timer0_cap_c,
   output logic timer0_cap_b,
   output logic timer0_cap_a,
   // Wake-up interrupt inputs.
   input wire port_cd_pin_pkg::wake_vec_type wakeup_mask_reg,
   output port_cd_pin_pkg::wake_vec_type wakeup_in,
   // Port D pins 7 and 6.
   input wire logic pin_d7_in,
   output logic pin_d7_out,
   output logic pin_d7_oe,
   input wire logic pin_d7_direction,
   input wire logic pin_d7_data,
   output logic pin_d7_level,
   input wire logic pin_d6_in,
   output logic pin_d6_out,
   output logic pin_d6_oe,
   input wire logic pin_d6_direction,
   input wire logic pin_d6_data,
   output logic pin_d6_level,
   // Serial unit control bits and signals.
   input wire logic serial_mode_select,
   input wire logic master_select,
   input wire logic cs_select_hi,
   input wire logic cs_select_lo,
   input wire logic serial_clk_pin_select,
   input wire logic serial_cs_drive,
   input wire logic serial_clk_drive,
   output logic serial_chip_select,
   output logic serial_clock_pin,
   output logic cs_input_enable,
   output logic cs_output_enable,
   output logic sclk_input_enable,
   output logic sclk_output_enable
);
   import port_cd_pin_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////

   // Capture routing is the same test for every compare/capture pin.
   function automatic logic capture_route(
      input logic normal_mode,
      input logic phase_mode,
      input io_field_type field
   );
      capture_route = normal_mode || (phase_mode && (field[3:2] == `IO_FIELD_CAPTURE_TOP));
   endfunction

   // True when any of the three channels picks the given prescaler code.
   function automatic logic any_psc_is(
      input psc_type code,
      input psc_type sel0,
      input psc_type sel1,
      input psc_type sel2
   );
      any_psc_is = (sel0 == code) || (sel1 == code) || (sel2 == code);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Port C output drivers.

   // Pin order is 5 down to 0: timer1 B, timer1 A, timer0 D, C, B, A.
   wire port_c_vec_type c_alt_out;
   wire port_c_vec_type c_alt_oe;

   assign c_alt_out = {timer1_cmp_b, timer1_cmp_a, timer0_cmp_d,
                       timer0_cmp_c, timer0_cmp_b, timer0_cmp_a}; // [RULE1] [RULE5] [RULE11] [RULE12]
   assign c_alt_oe = {timer1_cmp_b_oe, timer1_cmp_a_oe, timer0_cmp_d_oe,
                      timer0_cmp_c_oe, timer0_cmp_b_oe, timer0_cmp_a_oe};

   // Port C has no input-priority function, so the cells see no input enable.
   // The timer input routes below never turn the output driver off; a pin
   // driven by its compare output still loops back to its own capture input.
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_port_c
         pin_cell u_cell (
            .alt_in_en(1'b0),
            .alt_out_en(c_alt_oe[gi]),
            .alt_out(c_alt_out[gi]),
            .direction(pin_c_direction[gi]),
            .gpio_out(pin_c_data[gi]),
            .pin_out(pin_c_out[gi]),
            .pin_oe(pin_c_oe[gi])
         ); // [RULE1] [RULE5] [RULE11] [RULE12] [RULE20]
      end
   endgenerate

   assign pin_c_level = pin_c_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Timer inputs from port C.

   wire clk_a_sel;
   wire clk_b_sel;
   wire clk_c_sel;

   assign clk_c_sel = (timer0_prescaler_select == `PSC_EXT_CLK_C)
                      || (timer2_prescaler_select == `PSC_EXT_CLK_C) // [RULE2]
                      || timer1_phase_mode; // [RULE3]
   assign clk_b_sel = any_psc_is(`PSC_EXT_CLK_B, timer0_prescaler_select,
                                 timer1_prescaler_select, timer2_prescaler_select)
                      || timer0_phase_mode; // [RULE7]
   assign clk_a_sel = any_psc_is(`PSC_EXT_CLK_A, timer0_prescaler_select,
                                 timer1_prescaler_select, timer2_prescaler_select)
                      || timer0_phase_mode; // [RULE9]

   // Unrouted inputs rest low so the timer never sees a stray edge.
   assign ext_clk_in_c = clk_c_sel ? pin_c_in[5] : `ROUTE_IDLE; // [RULE2] [RULE3]
   assign ext_clk_in_b = clk_b_sel ? pin_c_in[3] : `ROUTE_IDLE; // [RULE7]
   assign ext_clk_in_a = clk_a_sel ? pin_c_in[2] : `ROUTE_IDLE; // [RULE9]

   wire cap_sel_1b;
   wire cap_sel_1a;
   wire cap_sel_0d;
   wire cap_sel_0c;
   wire cap_sel_0b;
   wire cap_sel_0a;

   assign cap_sel_1b = capture_route(timer1_normal_mode, timer1_phase_mode,
                                     timer1_io_field_b); // [RULE4]
   assign cap_sel_1a = capture_route(timer1_normal_mode, timer1_phase_mode,
                                     timer1_io_field_a); // [RULE6]
   assign cap_sel_0d = capture_route(timer0_normal_mode, timer0_phase_mode,
                                     timer0_io_field_d); // [RULE8]
   assign cap_sel_0c = capture_route(timer0_normal_mode, timer0_phase_mode,
                                     timer0_io_field_c); // [RULE10]
   assign cap_sel_0b = capture_route(timer0_normal_mode, timer0_phase_mode,
                                     timer0_io_field_b); // [RULE13]
   assign cap_sel_0a = capture_route(timer0_normal_mode, timer0_phase_mode,
                                     timer0_io_field_a); // [RULE14]

   assign timer1_cap_b = cap_sel_1b ? pin_c_in[5] : `ROUTE_IDLE; // [RULE4]
   assign timer1_cap_a = cap_sel_1a ? pin_c_in[4] : `ROUTE_IDLE; // [RULE6]
   assign timer0_cap_d = cap_sel_0d ? pin_c_in[3] : `ROUTE_IDLE; // [RULE8]
   assign timer0_cap_c = cap_sel_0c ? pin_c_in[2] : `ROUTE_IDLE; // [RULE10]
   assign timer0_cap_b = cap_sel_0b ? pin_c_in[1] : `ROUTE_IDLE; // [RULE13]
   assign timer0_cap_a = cap_sel_0a ? pin_c_in[0] : `ROUTE_IDLE; // [RULE14]

   ////////////////////////////////////////////////////////////////////////////////
   // Wake-up inputs run beside whatever else the pin is doing.

   generate
      for (gi = 0; gi < 6; gi++) begin : g_wake
         assign wakeup_in[gi + 8] = (wakeup_mask_reg[gi + 8] == `WAKE_UNMASKED)
                                    ? pin_c_in[gi] : `WAKE_IDLE; // [RULE15]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Port D pins 7 and 6.

   wire clocked_mode;

   assign clocked_mode = (serial_mode_select == `SERIAL_MODE_CLOCKED);
   assign cs_input_enable = clocked_mode && (!master_select
                            || (master_select && (cs_select_hi != cs_select_lo))); // [RULE16]
   assign cs_output_enable = clocked_mode && master_select && cs_select_hi; // [RULE17]
   assign sclk_input_enable = !master_select && serial_clk_pin_select; // [RULE18]
   assign sclk_output_enable = master_select && serial_clk_pin_select; // [RULE19]

   // Both enables can be true at once; the input side must win there.
   pin_cell u_cell_d7 (
      .alt_in_en(cs_input_enable),
      .alt_out_en(cs_output_enable),
      .alt_out(serial_cs_drive),
      .direction(pin_d7_direction),
      .gpio_out(pin_d7_data),
      .pin_out(pin_d7_out),
      .pin_oe(pin_d7_oe)
   ); // [RULE17] [RULE20]

   pin_cell u_cell_d6 (
      .alt_in_en(sclk_input_enable),
      .alt_out_en(sclk_output_enable),
      .alt_out(serial_clk_drive),
      .direction(pin_d6_direction),
      .gpio_out(pin_d6_data),
      .pin_out(pin_d6_out),
      .pin_oe(pin_d6_oe)
   ); // [RULE19] [RULE20]

   assign serial_chip_select = cs_input_enable ? pin_d7_in : `ROUTE_IDLE; // [RULE16]
   assign serial_clock_pin = sclk_input_enable ? pin_d6_in : `ROUTE_IDLE; // [RULE18]
   assign pin_d7_level = pin_d7_in;
   assign pin_d6_level = pin_d6_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks, sampled on the clock only; the logic itself has no state.

   property p_c5_cmp_out;
      @(posedge clk) disable iff (!nrst)
      timer1_cmp_b_oe |-> (pin_c_oe[5] && (pin_c_out[5] == timer1_cmp_b));
   endproperty
   a_c5_cmp_out: assert property (p_c5_cmp_out) else $error("C5 not driving compare B."); // [RULE1]

   property p_c4_gpio;
      @(posedge clk) disable iff (!nrst)
      !timer1_cmp_a_oe |-> ((pin_c_oe[4] == pin_c_direction[4])
                            && (!pin_c_oe[4] || (pin_c_out[4] == pin_c_data[4])));
   endproperty
   a_c4_gpio: assert property (p_c4_gpio) else $error("C4 general I/O wrong."); // [RULE5]

   property p_c0_cmp_out;
      @(posedge clk) disable iff (!nrst)
      timer0_cmp_a_oe |-> (pin_c_oe[0] && (pin_c_out[0] == timer0_cmp_a));
   endproperty
   a_c0_cmp_out: assert property (p_c0_cmp_out) else $error("C0 not driving compare A."); // [RULE12]

   property p_c3_gpio_in;
      @(posedge clk) disable iff (!nrst)
      (!timer0_cmp_d_oe && !pin_c_direction[3]) |-> !pin_c_oe[3];
   endproperty
   a_c3_gpio_in: assert property (p_c3_gpio_in) else $error("C3 driven as input."); // [RULE11]

   property p_clk_c;
      @(posedge clk) disable iff (!nrst)
      (timer1_phase_mode || (timer2_prescaler_select == 3'h6))
      |-> (ext_clk_in_c == pin_c_in[5]);
   endproperty
   a_clk_c: assert property (p_clk_c) else $error("External clock C not routed."); // [RULE2]

   property p_clk_b_off;
      @(posedge clk) disable iff (!nrst)
      (!timer0_phase_mode && (timer0_prescaler_select != 3'h5)
       && (timer1_prescaler_select != 3'h5) && (timer2_prescaler_select != 3'h5))
      |-> !ext_clk_in_b;
   endproperty
   a_clk_b_off: assert property (p_clk_b_off) else $error("External clock B leaks."); // [RULE7]

   property p_clk_a;
      @(posedge clk) disable iff (!nrst)
      (timer1_prescaler_select == 3'h4) |-> (ext_clk_in_a == pin_c_in[2]);
   endproperty
   a_clk_a: assert property (p_clk_a) else $error("External clock A not routed."); // [RULE9]

   property p_cap_phase;
      @(posedge clk) disable iff (!nrst)
      (!timer0_normal_mode && timer0_phase_mode && (timer0_io_field_c[3:2] != 2'h2))
      |-> !timer0_cap_c;
   endproperty
   a_cap_phase: assert property (p_cap_phase) else $error("Capture C wrongly routed."); // [RULE10]

   property p_cap_1b;
      @(posedge clk) disable iff (!nrst)
      timer1_normal_mode |-> ((timer1_cap_b == pin_c_in[5]) && (timer1_cap_a == pin_c_in[4]));
   endproperty
   a_cap_1b: assert property (p_cap_1b) else $error("Timer1 captures not routed."); // [RULE4]

   // A mask that opens and stays open a second cycle must pass the pin on that second cycle.
   sequence s_mask_opens;
      $fell(wakeup_mask_reg[8]);
   endsequence

   sequence s_mask_stays;
      (wakeup_mask_reg[8] == 1'b0) [*2];
   endsequence

   property p_wake_open;
      @(posedge clk) disable iff (!nrst)
      (s_mask_opens ##0 s_mask_stays) |-> (wakeup_in[8] == pin_c_in[0]);
   endproperty
   a_wake_open: assert property (p_wake_open) else $error("Wake-up 8 not passed."); // [RULE15]

   property p_wake_masked;
      @(posedge clk) disable iff (!nrst)
      wakeup_mask_reg[13] |-> wakeup_in[13];
   endproperty
   a_wake_masked: assert property (p_wake_masked) else $error("Masked wake-up 13 active."); // [RULE15]

   property p_cs_input_wins;
      @(posedge clk) disable iff (!nrst)
      cs_input_enable |-> (!pin_d7_oe && (serial_chip_select == pin_d7_in));
   endproperty
   a_cs_input_wins: assert property (p_cs_input_wins) else $error("D7 input not first."); // [RULE16]

   property p_cs_out;
      @(posedge clk) disable iff (!nrst)
      (!serial_mode_select && master_select && cs_select_hi && cs_select_lo)
      |-> (pin_d7_oe && (pin_d7_out == serial_cs_drive));
   endproperty
   a_cs_out: assert property (p_cs_out) else $error("D7 chip select not driven."); // [RULE17]

   property p_sclk_slave;
      @(posedge clk) disable iff (!nrst)
      (!master_select && serial_clk_pin_select)
      |-> (!pin_d6_oe && (serial_clock_pin == pin_d6_in));
   endproperty
   a_sclk_slave: assert property (p_sclk_slave) else $error("D6 clock input missing."); // [RULE18]

   property p_sclk_master;
      @(posedge clk) disable iff (!nrst)
      (master_select && serial_clk_pin_select) |-> (pin_d6_oe && (pin_d6_out == serial_clk_drive));
   endproperty
   a_sclk_master: assert property (p_sclk_master) else $error("D6 clock not driven."); // [RULE19]

   property p_same_cycle;
      @(posedge clk) disable iff (!nrst)
      ($changed(pin_c_direction[1]) && !timer0_cmp_b_oe)
      |-> (pin_c_oe[1] == pin_c_direction[1]);
   endproperty
   a_same_cycle: assert property (p_same_cycle) else $error("C1 direction change late."); // [RULE20]

endmodule

// ### tb/pin_partner.sv
// Package pin model for port C pins 5 to 0 and port D pins 7 and 6.
`timescale 1ns/1ps

module pin_partner (
   input wire port_cd_pin_pkg::port_c_vec_type pin_c_out,
   input wire port_cd_pin_pkg::port_c_vec_type pin_c_oe,
   input wire port_cd_pin_pkg::port_c_vec_type ext_c,
   output port_cd_pin_pkg::port_c_vec_type pin_c_in,
   input wire logic pin_d7_out,
   input wire logic pin_d7_oe,
   input wire logic ext_d7,
   output logic pin_d7_in,
   input wire logic pin_d6_out,
   input wire logic pin_d6_oe,
   input wire logic ext_d6,
   output logic pin_d6_in
);
   import port_cd_pin_pkg::*;
   // Contention is not modelled: while the block drives a pin, its value wins.
   assign pin_c_in = (pin_c_oe & pin_c_out) | (~pin_c_oe & ext_c);
   assign pin_d7_in = pin_d7_oe ? pin_d7_out : ext_d7;
   assign pin_d6_in = pin_d6_oe ? pin_d6_out : ext_d6;
endmodule

// ### tb/port_c_d_pin_function_select_tb.sv
// Self-checking bench for the port C and D pin function selection.
`timescale 1ns/1ps

module port_c_d_pin_function_select_tb;
   import port_cd_pin_pkg::*;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   port_c_vec_type pin_c_in, pin_c_out, pin_c_oe, pin_c_level, pin_c_direction, pin_c_data;
   port_c_vec_type ext_c, cv, coe;
   logic timer0_normal_mode, timer0_phase_mode, timer1_normal_mode, timer1_phase_mode;
   psc_type psc [3];
   io_field_type fld [6];
   wire logic [5:0] cap;
   wire logic [2:0] eck;
   wake_vec_type wakeup_mask_reg, wakeup_in;
   logic pin_d7_in, pin_d7_out, pin_d7_oe, pin_d7_direction, pin_d7_data, pin_d7_level, ext_d7;
   logic pin_d6_in, pin_d6_out, pin_d6_oe, pin_d6_direction, pin_d6_data, pin_d6_level, ext_d6;
   logic serial_mode_select, master_select, cs_select_hi, cs_select_lo, serial_clk_pin_select;
   logic serial_cs_drive, serial_clk_drive, serial_chip_select, serial_clock_pin;
   logic cs_input_enable, cs_output_enable, sclk_input_enable, sclk_output_enable;
   int mismatches = 0;
   int n_checks = 0;

   always #10 clk = ~clk;

   //////////////////////////////
   port_c_d_pin_function_select port_c_d_pin_function_select_inst (
      .clk, .nrst, .pin_c_in, .pin_c_out, .pin_c_oe, .pin_c_direction, .pin_c_data,
      .pin_c_level, .timer0_normal_mode, .timer0_phase_mode, .timer1_normal_mode,
      .timer1_phase_mode, .timer0_prescaler_select(psc[0]), .timer1_prescaler_select(psc[1]),
      .timer2_prescaler_select(psc[2]), .timer1_io_field_a(fld[4]), .timer1_io_field_b(fld[5]),
      .timer0_io_field_a(fld[0]), .timer0_io_field_b(fld[1]), .timer0_io_field_c(fld[2]),
      .timer0_io_field_d(fld[3]), .timer1_cmp_b(cv[5]), .timer1_cmp_b_oe(coe[5]),
      .timer1_cmp_a(cv[4]), .timer1_cmp_a_oe(coe[4]), .timer0_cmp_d(cv[3]),
      .timer0_cmp_d_oe(coe[3]), .timer0_cmp_c(cv[2]), .timer0_cmp_c_oe(coe[2]),
      .timer0_cmp_b(cv[1]), .timer0_cmp_b_oe(coe[1]), .timer0_cmp_a(cv[0]),
      .timer0_cmp_a_oe(coe[0]), .ext_clk_in_a(eck[0]), .ext_clk_in_b(eck[1]),
      .ext_clk_in_c(eck[2]), .timer1_cap_b(cap[5]), .timer1_cap_a(cap[4]),
      .timer0_cap_d(cap[3]), .timer0_cap_c(cap[2]), .timer0_cap_b(cap[1]),
      .timer0_cap_a(cap[0]), .wakeup_mask_reg, .wakeup_in, .pin_d7_in, .pin_d7_out,
      .pin_d7_oe, .pin_d7_direction, .pin_d7_data, .pin_d7_level, .pin_d6_in, .pin_d6_out,
      .pin_d6_oe, .pin_d6_direction, .pin_d6_data, .pin_d6_level, .serial_mode_select,
      .master_select, .cs_select_hi, .cs_select_lo, .serial_clk_pin_select,
      .serial_cs_drive, .serial_clk_drive, .serial_chip_select, .serial_clock_pin,
      .cs_input_enable, .cs_output_enable, .sclk_input_enable, .sclk_output_enable);

   pin_partner pin_partner_inst (.pin_c_out, .pin_c_oe, .ext_c, .pin_c_in, .pin_d7_out,
      .pin_d7_oe, .ext_d7, .pin_d7_in, .pin_d6_out, .pin_d6_oe, .ext_d6, .pin_d6_in);

   //////////////////////////////
   task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_vec({5'h0, got}, {5'h0, exp}, what);
   endtask

   task automatic finish_test();
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Outputs are judged 2 ns after the change, well before any clock edge.
   task automatic check_all();
      port_c_vec_type oe_e, out_e, lvl, cap_e, ph, nm;
      logic [2:0] ck_e;
      logic cie, coe7, oe7, lv7, sie, soe6, oe6, lv6;
      #2;
      ph = {{2{timer1_phase_mode}}, {4{timer0_phase_mode}}};
      nm = {{2{timer1_normal_mode}}, {4{timer0_normal_mode}}};
      oe_e = coe | pin_c_direction;
      out_e = (coe & cv) | (~coe & pin_c_data);
      lvl = (oe_e & out_e) | (~oe_e & ext_c);
      for (int i = 0; i < 6; i++) cap_e[i] = (nm[i] | (ph[i] & (fld[i][3:2] == 2'h2))) & lvl[i];
      ck_e[0] = (psc[0] == 3'h4 || psc[1] == 3'h4 || psc[2] == 3'h4 || timer0_phase_mode) && lvl[2];
      ck_e[1] = (psc[0] == 3'h5 || psc[1] == 3'h5 || psc[2] == 3'h5 || timer0_phase_mode) && lvl[3];
      ck_e[2] = (psc[0] == 3'h6 || psc[2] == 3'h6 || timer1_phase_mode) && lvl[5];
      cie = !serial_mode_select && (!master_select || (cs_select_hi ^ cs_select_lo));
      coe7 = !serial_mode_select && master_select && cs_select_hi;
      oe7 = !cie && (coe7 || pin_d7_direction);
      lv7 = oe7 ? (coe7 ? serial_cs_drive : pin_d7_data) : ext_d7;
      sie = !master_select && serial_clk_pin_select;
      soe6 = master_select && serial_clk_pin_select;
      oe6 = !sie && (soe6 || pin_d6_direction);
      lv6 = oe6 ? (soe6 ? serial_clk_drive : pin_d6_data) : ext_d6;
      chk_vec(pin_c_oe, oe_e, "pin_c_oe");
      chk_vec(pin_c_out & oe_e, out_e & oe_e, "pin_c_out");
      chk_vec(pin_c_level, lvl, "pin_c_level");
      chk_vec(cap, cap_e, "capture");
      chk_vec({3'h0, eck}, {3'h0, ck_e}, "ext_clk");
      chk_vec(wakeup_in, wakeup_mask_reg | lvl, "wakeup_in");
      chk_bit(cs_input_enable, cie, "cs_input_enable");
      chk_bit(cs_output_enable, coe7, "cs_output_enable");
      chk_bit(pin_d7_oe, oe7, "pin_d7_oe");
      chk_bit(pin_d7_out | !oe7, lv7 | !oe7, "pin_d7_out");
      chk_bit(pin_d7_level, lv7, "pin_d7_level");
      chk_bit(serial_chip_select, cie && lv7, "serial_chip_select");
      chk_bit(sclk_input_enable, sie, "sclk_input_enable");
      chk_bit(sclk_output_enable, soe6, "sclk_output_enable");
      chk_bit(pin_d6_oe, oe6, "pin_d6_oe");
      chk_bit(pin_d6_out | !oe6, lv6 | !oe6, "pin_d6_out");
      chk_bit(pin_d6_level, lv6, "pin_d6_level");
      chk_bit(serial_clock_pin, sie && lv6, "serial_clock_pin");
   endtask

   //////////////////////////////
   task automatic t_gpio();
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         pin_c_direction = k[0] ? 6'h2a : 6'h15;
         pin_c_data = k[1] ? 6'h33 : 6'h0c;
         ext_c = ~pin_c_data;
         {pin_d7_direction, pin_d6_direction, pin_d7_data, pin_d6_data} = {k[0], !k[0], k[1], k[1]};
         {ext_d7, ext_d6} = {2{!k[1]}};
         check_all();
      end
   endtask

   task automatic t_compare();
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         pin_c_direction = 6'h00;
         coe = 6'h01 << (i / 2);
         cv = i[0] ? 6'h3f : 6'h00;
         pin_c_data = ~cv;
         check_all();
      end
   endtask

   task automatic t_capture();
      for (int k = 0; k < 16; k++) begin
         @(negedge clk);
         coe = 6'h00;
         timer0_normal_mode = (k[3:2] == 2'h1);
         timer0_phase_mode = k[3];
         timer1_normal_mode = (k[3:2] == 2'h2);
         timer1_phase_mode = k[2];
         foreach (fld[j]) fld[j] = {k[1:0], 2'(j)};
         ext_c = k[0] ? 6'h2d : 6'h12;
         check_all();
      end
   endtask

   task automatic t_ext_clk();
      for (int k = 0; k < 48; k++) begin
         @(negedge clk);
         {timer0_normal_mode, timer0_phase_mode, timer1_normal_mode, timer1_phase_mode} = 4'h0;
         foreach (psc[j]) psc[j] = (j == (k % 24) / 8) ? 3'(k) : 3'h0;
         ext_c = (k >= 24) ? 6'h00 : 6'h3f;
         check_all();
      end
   endtask

   // Output pins must still reach their wake-up inputs, so C3 to C0 drive here.
   // C0 drives low so that an open mask is told apart from the idle level.
   task automatic t_wakeup();
      for (int k = 0; k < 12; k++) begin
         @(negedge clk);
         foreach (psc[j]) psc[j] = 3'h0;
         {pin_c_direction, pin_c_data} = {6'h0f, 6'h0a};
         wakeup_mask_reg = ~(6'h01 << (k / 2));
         ext_c = k[0] ? 6'h3f : 6'h00;
         check_all();
      end
   endtask

   task automatic t_serial();
      for (int k = 0; k < 64; k++) begin
         @(negedge clk);
         {serial_mode_select, master_select, cs_select_hi, cs_select_lo} = 4'(k >> 2);
         {serial_clk_pin_select, pin_d7_direction} = 2'(k);
         {pin_d6_direction, pin_d7_data, pin_d6_data} = {k[0], k[1], !k[1]};
         {serial_cs_drive, serial_clk_drive, ext_d7, ext_d6} = {!k[1], k[1], k[2], !k[3]};
         check_all();
      end
   endtask

   //////////////////////////////
   initial begin
      {pin_c_direction, pin_c_data, ext_c, cv, coe} = 30'h0;
      {timer0_normal_mode, timer0_phase_mode, timer1_normal_mode, timer1_phase_mode} = 4'h0;
      foreach (psc[j]) psc[j] = 3'h0;
      foreach (fld[j]) fld[j] = 4'h0;
      wakeup_mask_reg = 6'h3f;
      {pin_d7_direction, pin_d7_data, ext_d7, pin_d6_direction, pin_d6_data, ext_d6} = 6'h00;
      {serial_mode_select, master_select, cs_select_hi, cs_select_lo} = 4'h8;
      {serial_clk_pin_select, serial_cs_drive, serial_clk_drive} = 3'h0;
      repeat (4) @(negedge clk);
      nrst = 1'h1;
      t_gpio();
      t_compare();
      t_capture();
      t_ext_clk();
      t_wakeup();
      t_serial();
      finish_test();
   end

   // The scenarios need about 160 cycles; the limit leaves a wide margin.
   initial begin
      #100000;
      mismatches++;
      finish_test();
   end
endmodule
